// ### ufpc_pkg.sv
// Constants and types for the user flash program control block.
// Assumes an 8-bit core presenting SFR, data-space and code-space strobes on sys_clk_in.
// Overview of operation
// - After reset the user array is reachable only by code reads, read-only.
// - Latch map bit steers data writes 0000h-7FFFh into the column latches.
// - Latch map bit overrides the external-RAM select in data-space steering.
// - Space select picks user array, extra row, security byte or nothing.
// - Programming starts only after key nibble 5 then key nibble A.
// - First key does nothing; second programs the selected space; select 11 nothing.
// - Any other instruction between the two key writes aborts the launch.
// - Busy flag bit 0 is hardware owned, set while programming runs.
// - Boot-map bit maps the boot flash into code space F800h-FFFFh while the user array is selected.
// - Column latches accept from 1 to 128 bytes within one page.
// - Launch erases then programs only loaded bytes; unloaded bytes untouched.
// - The programmed page is that of the latest column-latch write.
// - User or extra-row launch is honoured only when run from boot flash.
// - Lock level 1 lets external code read internal bytes unencoded.
// - Level 2 bars external code reads, latches access pin, stops parallel programming.
// - Level 3 also bars parallel verify; level 4 bars external roll-over execution.
// - Lock bits written only in parallel mode; factory default is level 4.
// - Reset clears all eight control register bits.
package ufpc_pkg;
	localparam logic [7:0] UFPC_CTRL_ADDR = 8'hD1;
	localparam logic [7:0] UFPC_CTRL_RESET = 8'h00;
	localparam int UFPC_KEY_HI = 7;
	localparam int UFPC_KEY_LO = 4;
	localparam int UFPC_MAP_BIT = 3;
	localparam int UFPC_SEL_HI = 2;
	localparam int UFPC_SEL_LO = 1;
	localparam int UFPC_BUSY_BIT = 0;
	localparam logic [3:0] UFPC_KEY_FIRST = 4'h5;
	localparam logic [3:0] UFPC_KEY_SECOND = 4'hA;
	localparam int UFPC_PAGE_BYTES = 128;
	localparam int UFPC_PAGES = 256;
	localparam int UFPC_OFS_W = 7;
	localparam int UFPC_PAGE_W = 8;
	localparam logic [15:0] UFPC_USER_TOP = 16'h7FFF;
	localparam logic [15:0] UFPC_BOOT_BASE = 16'hF800;
	localparam logic [15:0] UFPC_EXTRA_ROW_BASE = 16'hFF80;
	localparam logic [15:0] UFPC_SECURITY_ADDR = 16'h0000;
	localparam logic [7:0] UFPC_ERASED = 8'hFF;
	// Lock bits held in security byte bits 2..0, programmed means zero
	localparam int UFPC_LOCK_LOW_BIT = 0;
	localparam int UFPC_LOCK_MID_BIT = 1;
	localparam int UFPC_LOCK_HIGH_BIT = 2;
	localparam logic [7:0] UFPC_SECURITY_RESET = 8'hFB;
	// Erase-plus-program interval
	localparam int UFPC_CLK_MHZ = 100;
	localparam int UFPC_PROG_TIME_US = 5;
	localparam int UFPC_PROG_CYCLES = UFPC_PROG_TIME_US * UFPC_CLK_MHZ;
	localparam int UFPC_CNT_W = 16;
	typedef enum logic [1:0] {UFPC_SEL_USER, UFPC_SEL_EXTRA_ROW, UFPC_SEL_SECURITY,
		UFPC_SEL_RESERVED} ufpc_space_t;
endpackage : ufpc_pkg

// ### ufpc_page_buffer.sv
// One 128-byte page of storage with a per-byte loaded mark.
// Used for the column latches only; writes are one byte per cycle.
`timescale 1ns/10ps
module ufpc_page_buffer
	import ufpc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	// Byte write
	input wire logic wr_en_in,
	input wire logic [UFPC_OFS_W-1:0] wr_ofs_in,
	input wire logic [7:0] wr_data_in,
	// Clear all loaded marks
	input wire logic clear_in,
	// Read port
	input wire logic [UFPC_OFS_W-1:0] rd_ofs_in,
	output logic [7:0] rd_data_out,
	output logic rd_loaded_out
);
	logic [7:0] byte_reg [UFPC_PAGE_BYTES];
	logic [UFPC_PAGE_BYTES-1:0] loaded_reg;

	always_ff @(posedge sys_clk_in)
	begin
		if (wr_en_in)
			byte_reg[wr_ofs_in] <= wr_data_in;
	end

	// Write wins over clear so a byte loaded in the clear cycle survives
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			loaded_reg <= '0;
		else
		begin
			if (clear_in)
				loaded_reg <= '0;
			if (wr_en_in)
				loaded_reg[wr_ofs_in] <= 1'b1;
		end
	end

	assign rd_data_out = byte_reg[rd_ofs_in];
	assign rd_loaded_out = loaded_reg[rd_ofs_in];
endmodule : ufpc_page_buffer

// ### ufpc_flash_control.sv
// Flash control register, column latches, key launch and program sequencer.
// Assumes one instruction per cpu_instr_in pulse; SFR and data/code strobes are one cycle.
// The user array is modelled as flip-flops so that erase and program are visible.
`timescale 1ns/10ps
module ufpc_flash_control
	import ufpc_pkg::*;
#(
	parameter int PROG_CYCLES = ufpc_pkg::UFPC_PROG_CYCLES
)
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	// Core instruction and SFR access
	input wire logic cpu_instr_in,
	input wire logic cpu_exec_boot_in,
	input wire logic cpu_exec_external_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	// Auxiliary control bits
	input wire logic boot_area_map_in,
	input wire logic external_ram_select_in,
	// Data space write
	input wire logic data_wr_in,
	input wire logic [15:0] data_addr_in,
	input wire logic [7:0] data_wdata_in,
	output logic data_to_latch_out,
	output logic data_to_xram_out,
	// Code space read
	input wire logic code_rd_in,
	input wire logic [15:0] code_addr_in,
	output logic [7:0] code_rdata_out,
	output logic code_from_boot_out,
	output logic code_denied_out,
	// Lock and pins
	input wire logic external_access_pin_in,
	input wire logic parallel_mode_in,
	input wire logic parallel_lock_wr_in,
	input wire logic [2:0] parallel_lock_data_in,
	output logic external_access_latched_out,
	output logic parallel_program_en_out,
	output logic parallel_verify_en_out,
	output logic rollover_exec_en_out,
	output logic [2:0] lock_level_out,
	output logic program_in_progress_out
);
	typedef enum logic [1:0] {UFPC_IDLE, UFPC_ERASE, UFPC_PROGRAM, UFPC_WAIT} ufpc_state_t;
	// Lock levels reported on lock_level_out
	localparam logic [2:0] UFPC_LEVEL_OPEN = 3'h1;
	localparam logic [2:0] UFPC_LEVEL_NO_EXT = 3'h2;
	localparam logic [2:0] UFPC_LEVEL_NO_VERIFY = 3'h3;
	localparam logic [2:0] UFPC_LEVEL_NO_ROLL = 3'h4;
	// Cell index: page number above the in-page offset
	localparam int UFPC_CELL_W = UFPC_PAGE_W + UFPC_OFS_W;
	// Software reaches only the upper nibble of the security byte
	localparam int UFPC_SEC_SW_HI = 7;
	localparam int UFPC_SEC_SW_LO = 4;

	logic [7:0] ctrl_reg;
	logic key_armed_reg;
	ufpc_state_t state_reg;
	ufpc_space_t target_reg;
	logic [UFPC_PAGE_W-1:0] page_reg;
	logic [UFPC_OFS_W-1:0] walk_reg;
	logic [UFPC_CNT_W-1:0] wait_reg;
	logic [7:0] user_reg [UFPC_PAGES*UFPC_PAGE_BYTES];
	logic [7:0] extra_row_reg [UFPC_PAGE_BYTES];
	logic [7:0] security_reg;
	logic ea_latched_reg;
	logic reset_seen_reg;
	logic [7:0] code_rdata_reg;
	logic busy;
	logic ctrl_wr;
	logic launch;
	logic latch_wr;
	logic latch_loaded;
	logic [7:0] latch_byte;
	logic [UFPC_CELL_W-1:0] cell_addr;
	logic ext_blocked;
	ufpc_space_t space;

	// Busy is decoded from the state, so it drops in the cycle the sequencer idles
	assign busy = (state_reg != UFPC_IDLE);
	assign space = ufpc_space_t'(ctrl_reg[UFPC_SEL_HI:UFPC_SEL_LO]);
	assign ctrl_wr = sfr_wr_in && (sfr_addr_in == UFPC_CTRL_ADDR);
	// Second key with an armed first key; user and extra row need boot code
	// A refused second key still disarms, so a retry needs both writes again
	assign launch = ctrl_wr && key_armed_reg && !busy
		&& (sfr_wdata_in[UFPC_KEY_HI:UFPC_KEY_LO] == UFPC_KEY_SECOND)
		&& (space != UFPC_SEL_RESERVED)
		&& (cpu_exec_boot_in || space == UFPC_SEL_SECURITY);

	// Data-space steering
	// Decoded from the map bit and the address; the strobe only gates the latch write
	assign data_to_latch_out = ctrl_reg[UFPC_MAP_BIT] && (data_addr_in <= UFPC_USER_TOP);
	assign data_to_xram_out = !data_to_latch_out && external_ram_select_in;
	assign latch_wr = data_wr_in && data_to_latch_out && !busy;

	// Control register: only the key, map and select bits are software owned
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			ctrl_reg <= UFPC_CTRL_RESET;
		else if (ctrl_wr)
			ctrl_reg <= {sfr_wdata_in[UFPC_KEY_HI:UFPC_SEL_LO], 1'b0};
	end

	// First key arms; any following instruction that is not the second key disarms
	// A first key with cpu_instr_in also set still arms: the write takes priority
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			key_armed_reg <= 1'b0;
		else if (ctrl_wr)
			key_armed_reg <= (sfr_wdata_in[UFPC_KEY_HI:UFPC_KEY_LO] == UFPC_KEY_FIRST);
		else if (cpu_instr_in)
			key_armed_reg <= 1'b0;
	end

	// Latest latch write fixes the page
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			page_reg <= '0;
		else if (latch_wr)
			page_reg <= data_addr_in[UFPC_CELL_W-1:UFPC_OFS_W];
	end

	// Marks clear on the last busy cycle, so the next load starts a fresh page
	ufpc_page_buffer u_latches (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.wr_en_in(latch_wr),
		.wr_ofs_in(data_addr_in[UFPC_OFS_W-1:0]),
		.wr_data_in(data_wdata_in),
		.clear_in(state_reg == UFPC_WAIT && wait_reg == '0),
		.rd_ofs_in(walk_reg),
		.rd_data_out(latch_byte),
		.rd_loaded_out(latch_loaded)
	);

	assign cell_addr = {page_reg, walk_reg};

	// Sequencer: erase pass, program pass, then hold busy for the interval
	// Each pass walks the full page; the cells act only on loaded offsets
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_reg <= UFPC_IDLE;
			target_reg <= UFPC_SEL_USER;
			walk_reg <= '0;
			wait_reg <= '0;
		end
		else
		begin
			unique case (state_reg)
				UFPC_IDLE:
					if (launch)
					begin
						state_reg <= UFPC_ERASE;
						target_reg <= space;
						walk_reg <= '0;
					end
				UFPC_ERASE:
				begin
					walk_reg <= walk_reg + 1'b1;
					if (walk_reg == UFPC_OFS_W'(UFPC_PAGE_BYTES - 1))
						state_reg <= UFPC_PROGRAM;
				end
				UFPC_PROGRAM:
				begin
					walk_reg <= walk_reg + 1'b1;
					if (walk_reg == UFPC_OFS_W'(UFPC_PAGE_BYTES - 1))
					begin
						state_reg <= UFPC_WAIT;
						wait_reg <= UFPC_CNT_W'(PROG_CYCLES - 1);
					end
				end
				UFPC_WAIT:
					if (wait_reg == '0)
						state_reg <= UFPC_IDLE;
					else
						wait_reg <= wait_reg - 1'b1;
			endcase
		end
	end

	// Array cells: erase then program only loaded bytes
	// Reset fills both arrays with the erased value so unwritten reads are defined
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			for (int i = 0; i < UFPC_PAGES * UFPC_PAGE_BYTES; i++)
				user_reg[i] <= UFPC_ERASED;
			for (int i = 0; i < UFPC_PAGE_BYTES; i++)
				extra_row_reg[i] <= UFPC_ERASED;
		end
		else if (latch_loaded && (state_reg == UFPC_ERASE || state_reg == UFPC_PROGRAM))
		begin
			if (target_reg == UFPC_SEL_USER)
				user_reg[cell_addr] <= (state_reg == UFPC_ERASE) ? UFPC_ERASED
					: latch_byte;
			else if (target_reg == UFPC_SEL_EXTRA_ROW)
				extra_row_reg[walk_reg] <= (state_reg == UFPC_ERASE) ? UFPC_ERASED
					: latch_byte;
		end
	end

	// Security byte: software reaches high nibble only, lock bits via parallel mode
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			security_reg <= UFPC_SECURITY_RESET;
		else if (parallel_mode_in && parallel_lock_wr_in)
			security_reg[UFPC_LOCK_HIGH_BIT:UFPC_LOCK_LOW_BIT] <= parallel_lock_data_in;
		else if (state_reg == UFPC_PROGRAM && target_reg == UFPC_SEL_SECURITY
			&& latch_loaded && walk_reg == UFPC_SECURITY_ADDR[UFPC_OFS_W-1:0])
			security_reg[UFPC_SEC_SW_HI:UFPC_SEC_SW_LO]
				<= latch_byte[UFPC_SEC_SW_HI:UFPC_SEC_SW_LO];
	end

	// Level from lowest-ranked programmed bit upward; highest programmed wins
	always_comb
	begin
		lock_level_out = UFPC_LEVEL_OPEN;
		if (!security_reg[UFPC_LOCK_LOW_BIT])
			lock_level_out = UFPC_LEVEL_NO_EXT;
		if (!security_reg[UFPC_LOCK_MID_BIT])
			lock_level_out = UFPC_LEVEL_NO_VERIFY;
		if (!security_reg[UFPC_LOCK_HIGH_BIT])
			lock_level_out = UFPC_LEVEL_NO_ROLL;
	end

	// Access pin caught once at the first clock after reset release
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			ea_latched_reg <= 1'b0;
			reset_seen_reg <= 1'b0;
		end
		else if (!reset_seen_reg)
		begin
			reset_seen_reg <= 1'b1;
			ea_latched_reg <= external_access_pin_in;
		end
	end

	// Below level 2 nothing is held: the pin passes straight through
	assign external_access_latched_out = (lock_level_out >= UFPC_LEVEL_NO_EXT) ? ea_latched_reg
		: external_access_pin_in;
	assign parallel_program_en_out = (lock_level_out < UFPC_LEVEL_NO_EXT);
	assign parallel_verify_en_out = (lock_level_out < UFPC_LEVEL_NO_VERIFY);
	assign rollover_exec_en_out = (lock_level_out < UFPC_LEVEL_NO_ROLL);
	assign ext_blocked = cpu_exec_external_in && (lock_level_out >= UFPC_LEVEL_NO_EXT);

	// Code-space read, registered one cycle
	// Boot map wins only in the user select; row and fuse reads ignore it
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			code_rdata_reg <= '0;
			code_from_boot_out <= 1'b0;
			code_denied_out <= 1'b0;
		end
		else if (code_rd_in)
		begin
			code_from_boot_out <= 1'b0;
			code_denied_out <= ext_blocked;
			code_rdata_reg <= UFPC_ERASED;
			if (ext_blocked)
				code_rdata_reg <= UFPC_ERASED;
			else if (boot_area_map_in && code_addr_in >= UFPC_BOOT_BASE
				&& space == UFPC_SEL_USER)
				code_from_boot_out <= 1'b1;
			else
				unique case (space)
					UFPC_SEL_USER:
						if (code_addr_in <= UFPC_USER_TOP)
							code_rdata_reg <= user_reg[code_addr_in[UFPC_CELL_W-1:0]];
					UFPC_SEL_EXTRA_ROW:
						code_rdata_reg <= extra_row_reg[code_addr_in[UFPC_OFS_W-1:0]];
					UFPC_SEL_SECURITY:
						code_rdata_reg <= security_reg;
					UFPC_SEL_RESERVED:
						code_rdata_reg <= UFPC_ERASED;
				endcase
		end
	end

	assign code_rdata_out = code_rdata_reg;
	assign program_in_progress_out = busy;
	assign sfr_rdata_out = (sfr_rd_in && sfr_addr_in == UFPC_CTRL_ADDR)
		? {ctrl_reg[UFPC_KEY_HI:UFPC_SEL_LO], busy} : 8'h00;
endmodule : ufpc_flash_control

// ### ufpc_monitor.sv
// Checker watching the flash control ports: launch, busy, steering and lock outputs.
// Assumes one clock domain and the asynchronous active-low reset of the block.
`timescale 1ns/10ps
module ufpc_monitor
	import ufpc_pkg::*;
#(
	parameter int PROG_CYCLES = ufpc_pkg::UFPC_PROG_CYCLES
)
(
	input wire logic sys_clk_in, reset_n_in, cpu_instr_in, cpu_exec_boot_in, cpu_exec_external_in,
	input wire logic sfr_wr_in, sfr_rd_in, code_rd_in, data_to_latch_out, data_to_xram_out,
	input wire logic code_denied_out, parallel_program_en_out, parallel_verify_en_out,
	input wire logic rollover_exec_en_out, program_in_progress_out,
	input wire logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, code_rdata_out,
	input wire logic [15:0] data_addr_in,
	input wire logic [2:0] lock_level_out
);
	localparam int BUSY_LEN = 256 + PROG_CYCLES;
	logic armed_reg;
	logic map_reg;
	logic [15:0] cnt_reg;
	wire logic d1_wr = sfr_wr_in && sfr_addr_in == UFPC_CTRL_ADDR;
	wire logic [1:0] sel = sfr_wdata_in[2:1];
	wire logic launch = d1_wr && armed_reg && sfr_wdata_in[7:4] == UFPC_KEY_SECOND
		&& sel != 2'h3 && !program_in_progress_out && (cpu_exec_boot_in || sel == 2'h2);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	// Key stays armed only until some other instruction completes
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
		if (!reset_n_in) armed_reg <= 1'b0;
		else if (d1_wr) armed_reg <= sfr_wdata_in[7:4] == UFPC_KEY_FIRST;
		else if (cpu_instr_in) armed_reg <= 1'b0;
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
		if (!reset_n_in) map_reg <= 1'b0;
		else if (d1_wr) map_reg <= sfr_wdata_in[UFPC_MAP_BIT];
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
		if (!reset_n_in) cnt_reg <= 16'h0000;
		else cnt_reg <= program_in_progress_out ? cnt_reg + 16'h0001 : 16'h0000;
	sequence key_pair;
		d1_wr && sfr_wdata_in[7:4] == UFPC_KEY_FIRST ##1 !d1_wr ##1 launch;
	endsequence
	a_launch_busy: assert property (key_pair |=> program_in_progress_out)
		else $error("busy did not follow a valid key pair");
	a_busy_cause: assert property ($rose(program_in_progress_out) |-> $past(launch))
		else $error("busy rose without a valid launch");
	a_busy_length: assert property ($fell(program_in_progress_out) |-> cnt_reg == BUSY_LEN)
		else $error("busy interval has the wrong length");
	a_latch_steer: assert property (!program_in_progress_out |->
		data_to_latch_out == (map_reg && data_addr_in <= UFPC_USER_TOP))
		else $error("latch steering wrong");
	a_xram_override: assert property (map_reg && data_addr_in <= UFPC_USER_TOP |-> !data_to_xram_out)
		else $error("external RAM selected while latch map set");
	a_busy_bit_read: assert property (sfr_rd_in && sfr_addr_in == UFPC_CTRL_ADDR |->
		sfr_rdata_out[0] == program_in_progress_out && sfr_rdata_out[3] == map_reg)
		else $error("control read shows wrong busy or map");
	a_ext_denied: assert property (code_rd_in && cpu_exec_external_in
		&& lock_level_out >= 3'h2 |=> code_denied_out && code_rdata_out == UFPC_ERASED)
		else $error("external code read not barred");
	a_lock_top: assert property (lock_level_out == 3'h4 |->
		!parallel_program_en_out && !parallel_verify_en_out && !rollover_exec_en_out)
		else $error("level 4 protections missing");
	a_lock_open: assert property (lock_level_out == 3'h1 |->
		parallel_program_en_out && parallel_verify_en_out && rollover_exec_en_out)
		else $error("level 1 wrongly restricted");
endmodule : ufpc_monitor
bind ufpc_flash_control ufpc_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon (.sys_clk_in, .reset_n_in,
	.cpu_instr_in, .cpu_exec_boot_in, .cpu_exec_external_in, .sfr_wr_in, .sfr_rd_in, .code_rd_in,
	.data_to_latch_out, .data_to_xram_out, .code_denied_out, .parallel_program_en_out,
	.parallel_verify_en_out, .rollover_exec_en_out, .program_in_progress_out, .sfr_addr_in,
	.sfr_wdata_in, .sfr_rdata_out, .code_rdata_out, .data_addr_in, .lock_level_out);

// ### ufpc_core_model.sv
// Core model: issues control writes, latch loads and code reads toward the block.
// Assumes its tasks are called from one bench process; strobes last one cycle.
`timescale 1ns/10ps
module ufpc_core_model
	import ufpc_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic [7:0] sfr_rdata_in, code_rdata_in,
	output logic instr_out, boot_out, ext_out, sfr_wr_out, sfr_rd_out, data_wr_out, code_rd_out,
	output logic [7:0] sfr_addr_out, sfr_wdata_out, data_wdata_out,
	output logic [15:0] data_addr_out, code_addr_out
);
	initial {instr_out, boot_out, ext_out, sfr_wr_out, sfr_rd_out, data_wr_out, code_rd_out} = 7'h20;
	initial {sfr_addr_out, sfr_wdata_out, data_wdata_out, data_addr_out, code_addr_out} = '0;
	task automatic step();
		@(posedge sys_clk_in);
		#1;
	endtask : step
	// Released buses show the inverse so stale values cannot pass as fresh
	task automatic sfr_w(input logic [7:0] a, input logic [7:0] d, input logic ins);
		step();
		{sfr_wr_out, instr_out, sfr_addr_out, sfr_wdata_out} = {1'b1, ins, a, d};
		step();
		{sfr_wr_out, instr_out, sfr_addr_out, sfr_wdata_out} = {2'b00, ~a, ~d};
	endtask : sfr_w
	task automatic sfr_r(input logic [7:0] a, output logic [7:0] d);
		step();
		{sfr_rd_out, instr_out, sfr_addr_out} = {2'b11, a};
		#1 d = sfr_rdata_in;
		step();
		{sfr_rd_out, instr_out, sfr_addr_out} = {2'b00, ~a};
	endtask : sfr_r
	task automatic code_r(input logic [15:0] a, input logic ext, output logic [7:0] d);
		step();
		{code_rd_out, instr_out, ext_out, code_addr_out} = {2'b11, ext, a};
		step();
		{code_rd_out, instr_out, code_addr_out} = {2'b00, ~a};
		d = code_rdata_in;
	endtask : code_r
	task automatic load(input logic [1:0] sel, input logic [15:0] a, input logic [7:0] d);
		sfr_w(UFPC_CTRL_ADDR, {4'h0, 1'b1, sel, 1'b0}, 1'b1);
		step();
		{data_wr_out, instr_out, data_addr_out, data_wdata_out} = {2'b11, a, d};
		step();
		{data_wr_out, instr_out, data_addr_out, data_wdata_out} = {2'b00, ~a, ~d};
		sfr_w(UFPC_CTRL_ADDR, 8'h00, 1'b1);
	endtask : load
	// Interrupts are never taken by this core; only the gap read of SFR 80h breaks the pair
	task automatic launch(input logic [1:0] sel, input logic gap, input logic boot);
		logic [7:0] scratch;
		boot_out = boot;
		sfr_w(UFPC_CTRL_ADDR, {UFPC_KEY_FIRST, 1'b0, sel, 1'b0}, 1'b0);
		if (gap)
			sfr_r(8'h80, scratch);
		sfr_w(UFPC_CTRL_ADDR, {UFPC_KEY_SECOND, 1'b0, sel, 1'b0}, 1'b1);
		boot_out = 1'b1;
	endtask : launch
	task automatic rd_space(input logic [1:0] sel, input logic [15:0] a, output logic [7:0] d);
		sfr_w(UFPC_CTRL_ADDR, {4'h0, 1'b0, sel, 1'b0}, 1'b1);
		code_r(a, 1'b0, d);
		sfr_w(UFPC_CTRL_ADDR, 8'h00, 1'b1);
	endtask : rd_space
endmodule : ufpc_core_model

// ### tb_top.sv
// Bench: reference model of user array, extra row and security byte checked at every code read of the 12 tests and at the open external read.
// Assumes the core model drives all core strobes; lock pins and aux bits are driven here.
`timescale 1ns/10ps
module tb_top;
	import ufpc_pkg::*;
	localparam int PROG = 4;
	logic sys_clk_in = 1'b0, reset_n_in = 1'b0, ram_sel = 1'b0, pmode = 1'b0, plw = 1'b0;
	logic bmap = 1'b0, eapin = 1'b1;
	logic [2:0] pdata = 3'h0;
	logic instr, boot, ext, swr, srd, dwr, crd, lat, xr, den, frb, eal, ppe, pve, roe, bsy;
	logic [7:0] sad, swd, dwd, srdata, crdata, d;
	logic [15:0] dad, cad;
	logic [2:0] lvl;
	logic [7:0] usr[int], xrw[int], lt[int];
	logic [7:0] sec = UFPC_SECURITY_RESET;
	logic [31:0] seed = 32'h0000549E;
	int pg, sel, o, a, miscompares = 0, comparisons = 0;
	int q[$];
	logic ok;
	always #5 sys_clk_in = ~sys_clk_in;
	ufpc_core_model core (.sys_clk_in, .sfr_rdata_in(srdata), .code_rdata_in(crdata),
		.instr_out(instr), .boot_out(boot), .ext_out(ext), .sfr_wr_out(swr), .sfr_rd_out(srd),
		.data_wr_out(dwr), .code_rd_out(crd), .sfr_addr_out(sad), .sfr_wdata_out(swd),
		.data_wdata_out(dwd), .data_addr_out(dad), .code_addr_out(cad));
	ufpc_flash_control #(.PROG_CYCLES(PROG)) DUT (.sys_clk_in, .reset_n_in, .cpu_instr_in(instr),
		.cpu_exec_boot_in(boot), .cpu_exec_external_in(ext), .sfr_wr_in(swr), .sfr_rd_in(srd),
		.sfr_addr_in(sad), .sfr_wdata_in(swd), .sfr_rdata_out(srdata), .boot_area_map_in(bmap),
		.external_ram_select_in(ram_sel), .data_wr_in(dwr), .data_addr_in(dad),
		.data_wdata_in(dwd), .data_to_latch_out(lat), .data_to_xram_out(xr), .code_rd_in(crd),
		.code_addr_in(cad), .code_rdata_out(crdata), .code_from_boot_out(frb),
		.code_denied_out(den), .external_access_pin_in(eapin), .parallel_mode_in(pmode),
		.parallel_lock_wr_in(plw), .parallel_lock_data_in(pdata),
		.external_access_latched_out(eal), .parallel_program_en_out(ppe),
		.parallel_verify_en_out(pve), .rollover_exec_en_out(roe), .lock_level_out(lvl),
		.program_in_progress_out(bsy));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [7:0] mrd(input int s, input int ad);
		if (s == 0)
			return usr.exists(ad) ? usr[ad] : UFPC_ERASED;
		if (s == 1)
			return xrw.exists(ad % 128) ? xrw[ad % 128] : UFPC_ERASED;
		return sec;
	endfunction : mrd
	task automatic check(input string n, input logic [7:0] e, input logic [7:0] s);
		comparisons++;
		if (s !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic results();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results
	// Spans about twelve times the expected run
	initial
	begin
		#200000;
		miscompares++;
		results();
	end
	initial
	begin
		repeat (6) @(posedge sys_clk_in);
		#1 reset_n_in = 1'b1;
		core.sfr_r(UFPC_CTRL_ADDR, d);
		check("control reset", UFPC_CTRL_RESET, d);
		check("lock reset", 8'h04, {5'h00, lvl});
		eapin = 1'b0;
		for (int i = 0; i < 12; i++)
		begin
			sel = i % 4;
			ok = sel != 3 && i / 4 != 2 && (i / 4 != 1 || sel == 2);
			ram_sel = rnd() % 2;
			q.delete();
			repeat (3)
			begin
				o = sel == 2 ? 0 : int'(rnd() % 128);
				pg = int'(rnd() % 256);
				d = rnd();
				core.load(2'(sel), 16'(pg * 128 + o), d);
				lt[o] = d;
				q.push_back(pg * 128 + o);
			end
			q.push_back(int'(rnd() % 32768));
			core.launch(2'(sel), i / 4 == 2, i / 4 != 1);
			core.sfr_r(UFPC_CTRL_ADDR, d);
			check("busy bit", {7'h00, ok}, {7'h00, d[0]});
			for (int w = 0; w < 400 && bsy !== 1'b0; w++)
				@(posedge sys_clk_in);
			#1 check("busy end", 8'h00, {7'h00, bsy});
			if (ok)
			begin
				foreach (lt[k])
					if (sel == 0) usr[pg * 128 + k] = lt[k];
					else if (sel == 1) xrw[k] = lt[k];
				if (sel == 2) sec = {lt[0][7:4], sec[3:0]};
				lt.delete();
			end
			foreach (q[k])
			begin
				a = (sel == 1 && k < 3) ? 16'hFF80 + q[k] % 128 : sel == 2 ? 0 : q[k];
				core.rd_space(2'(sel == 3 || k == 3 ? 0 : sel), 16'(a), d);
				check("code read", mrd(sel == 3 || k == 3 ? 0 : sel, a), d);
			end
			$display("test %0d done", i);
		end
		bmap = 1'b1;
		core.rd_space(2'h0, 16'hF9A5, d);
		check("boot map on", 8'h01, {7'h00, frb});
		bmap = 1'b0;
		core.rd_space(2'h0, 16'hF9A5, d);
		check("boot map off", 8'h00, {7'h00, frb});
		check("above user array", UFPC_ERASED, d);
		$display("boot map test done");
		foreach (usr[k])
			a = k;
		core.code_r(16'(a), 1'b1, d);
		check("locked external read", UFPC_ERASED, d);
		check("access latched", 8'h01, {7'h00, eal});
		plw = 1'b1;
		pdata = 3'h7;
		@(posedge sys_clk_in);
		#1 check("lock without mode", 8'h04, {5'h00, lvl});
		pmode = 1'b1;
		@(posedge sys_clk_in);
		#1 {pmode, plw} = 2'b00;
		check("lock in mode", 8'h01, {5'h00, lvl});
		check("access follows pin", 8'h00, {7'h00, eal});
		core.code_r(16'(a), 1'b1, d);
		check("open external read", mrd(0, a), d);
		$display("lock test done");
		results();
	end
endmodule : tb_top
